// >>> design/acs_aux_divider.v
// auxiliary clock output divider, glitch-free ratio change
`timescale 1ns/100ps
module acs_aux_divider (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // control
  input  wire       src_clk_en,
  input  wire [2:0] div_sel,
  // output
  output reg        div_out
);

  reg [7:0] count;
  reg [7:0] half;
  reg [7:0] next_half;

  // setting to half period count minus one; 111 bypasses
  always @* begin
    case (div_sel)
      3'h6:    next_half = 8'h00;
      3'h5:    next_half = 8'h01;
      3'h4:    next_half = 8'h03;
      3'h3:    next_half = 8'h07;
      3'h2:    next_half = 8'h0F;
      3'h1:    next_half = 8'h1F;
      3'h0:    next_half = 8'h7F;
      default: next_half = 8'h00;
    endcase
  end

  // toggling counter; new ratio loaded at output falling edge
  // outside bypass no tick holds phase and count; bypass drives the
  // output low, so sparse ticks divide true at every ratio
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count   <= 8'h00;
      half    <= 8'h00;
      div_out <= 1'b0;
    end else if (div_sel == 3'h7 && half == 8'h00) begin
      // divide by 1 passes each tick
      count   <= 8'h00;
      div_out <= src_clk_en;
    end else if (src_clk_en) begin
      if (count >= half) begin
        count   <= 8'h00;
        div_out <= ~div_out;
        if (div_out)
          half <= next_half;
      end else begin
        count <= count + 8'h01;
      end
    end
  end

endmodule // acs_aux_divider

// >>> design/acs_clock_ctrl.v
// auxiliary clock and oscillator switch control with apb slave
//
// Summary of operation
// - aux pll runs only when enabled
// - read-only lock bit shows pll lock
// - divider source: aux osc or primary vco
// - three-bit output divider, 1 to 256
// - reference: primary, none, or internal rc
// - registers reset only on power-on
// - clock fail flag sticky until cleared
// - switch request self-clears when done
// - oscillator register writes need unlock
// - no direct pll to pll mode switch
// - unimplemented bits read zero
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "acs_consts.vh"
module acs_clock_ctrl #(
  parameter LOCK_CYCLES = 100
) (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // clock system status
  input  wire        fail_detect,
  input  wire        aux_osc_clk_en,
  input  wire        pri_vco_clk_en,
  // clock system control
  output reg         aux_pll_run,
  output reg  [1:0]  aux_pll_ref,
  output reg  [2:0]  cur_osc,
  output reg         aux_clk_out,
  output reg         irq
);

  localparam ST_IDLE   = 2'h0;
  localparam ST_KEY1   = 2'h1;
  localparam ST_OPEN   = 2'h2;
  localparam SW_IDLE   = 1'b0;
  localparam SW_BUSY   = 1'b1;

  reg [15:0] osc_reg;
  reg [15:0] aclk_reg;
  reg [1:0]  ulk_state;
  reg        sw_state;
  reg [7:0]  sw_count;
  reg [15:0] lock_count;
  reg        locked;
  reg [2:0]  irq_stat;
  reg [2:0]  irq_en;
  reg        locked_d;
  reg        sw_done;
  reg        sw_reject;
  reg [31:0] next_rdata;
  reg [1:0]  next_ulk_state;
  wire       div_clk;
  wire       wr_en;
  wire       rd_en;
  wire       osc_wr;
  wire [2:0] evt;
  wire [2:0] next_irq_stat;
  wire       hit_osc;
  wire       hit_aclk;
  wire       hit_unlock;
  wire       hit_irq_en;
  wire       hit_irq_clr;
  genvar     gi;

  // is a pll mode
  function is_pll;
    input [2:0] m;
    begin
      is_pll = (m == `ACS_OSC_INTERNAL_RC_WITH_PLL_MODE) || (m == `ACS_OSC_PRIPLL);
    end
  endfunction

  assign wr_en  = psel & penable & pwrite;
  assign rd_en  = psel & ~penable & ~pwrite;
  // register hits, shared by writes and the unlock sequence
  assign hit_osc     = (paddr == `ACS_OFF_OSC);
  assign hit_aclk    = (paddr == `ACS_OFF_ACLK);
  assign hit_unlock  = (paddr == `ACS_OFF_UNLOCK);
  assign hit_irq_en  = (paddr == `ACS_OFF_IRQ_EN);
  assign hit_irq_clr = (paddr == `ACS_OFF_IRQ_CLR);
  assign osc_wr = wr_en && hit_osc && ulk_state == ST_OPEN;

  // unlock sequence: two key writes then one open write
  always @* begin
    next_ulk_state = ulk_state;
    if (wr_en) begin
      case (ulk_state)
        ST_IDLE: begin
          if (hit_unlock && pwdata[15:0] == `ACS_UNLOCK_KEY1)
            next_ulk_state = ST_KEY1;
          else
            next_ulk_state = ST_IDLE;
        end
        ST_KEY1: begin
          if (hit_unlock && pwdata[15:0] == `ACS_UNLOCK_KEY2)
            next_ulk_state = ST_OPEN;
          else if (hit_unlock && pwdata[15:0] == `ACS_UNLOCK_KEY1)
            next_ulk_state = ST_KEY1;
          else
            next_ulk_state = ST_IDLE;
        end
        default: begin
          // any write after the open one relocks
          if (hit_unlock && pwdata[15:0] == `ACS_UNLOCK_KEY1)
            next_ulk_state = ST_KEY1;
          else
            next_ulk_state = ST_IDLE;
        end
      endcase
    end
  end

  // unlock state register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ulk_state <= ST_IDLE;
    else
      ulk_state <= next_ulk_state;
  end

  // oscillator control register; presetn is the power-on reset
  // power-on only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_reg <= `ACS_OSC_RESET;
    end else begin
      if (osc_wr)
        osc_reg[`ACS_NOSC_HI:`ACS_NOSC_LO] <=
          pwdata[`ACS_NOSC_HI:`ACS_NOSC_LO];
      if (fail_detect)
        osc_reg[`ACS_BIT_CF] <= 1'b1;
      else if (osc_wr && !pwdata[`ACS_BIT_CF])
        osc_reg[`ACS_BIT_CF] <= 1'b0;
      if (sw_done || sw_reject)
        osc_reg[`ACS_BIT_SWREQ] <= 1'b0;
      else if (osc_wr && pwdata[`ACS_BIT_SWREQ])
        osc_reg[`ACS_BIT_SWREQ] <= 1'b1;
    end
  end

  // switch sequencer; pll to pll requests are refused
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_state  <= SW_IDLE;
      sw_count  <= 8'h00;
      cur_osc   <= `ACS_OSC_FRC;
      sw_done   <= 1'b0;
      sw_reject <= 1'b0;
    end else begin
      sw_done   <= 1'b0;
      sw_reject <= 1'b0;
      case (sw_state)
        SW_IDLE: begin
          if (osc_reg[`ACS_BIT_SWREQ] && !sw_done && !sw_reject) begin
            if (is_pll(cur_osc) &&
                is_pll(osc_reg[`ACS_NOSC_HI:`ACS_NOSC_LO]) &&
                cur_osc != osc_reg[`ACS_NOSC_HI:`ACS_NOSC_LO])
              sw_reject <= 1'b1;
            else begin
              sw_state <= SW_BUSY;
              sw_count <= `ACS_SWITCH_CYCLES;
            end
          end
        end
        default: begin
          if (sw_count == 8'h00) begin
            cur_osc  <= osc_reg[`ACS_NOSC_HI:`ACS_NOSC_LO];
            sw_done  <= 1'b1;
            sw_state <= SW_IDLE;
          end else begin
            sw_count <= sw_count - 8'h01;
          end
        end
      endcase
    end
  end

  // auxiliary clock control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      aclk_reg <= `ACS_ACLK_RESET;
    else if (wr_en && hit_aclk)
      aclk_reg <= pwdata[15:0] & `ACS_ACLK_WMASK;
  end

  // lock timer; lock is lost whenever the pll stops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_count  <= 16'h0000;
      locked      <= 1'b0;
      aux_pll_run <= 1'b0;
      aux_pll_ref <= 2'h0;
      locked_d    <= 1'b0;
    end else begin
      aux_pll_run <= aclk_reg[`ACS_BIT_AUX_PLL_ENABLE];
      if (aclk_reg[`ACS_BIT_RCSEL])
        aux_pll_ref <= 2'h2;
      else if (aclk_reg[`ACS_BIT_REFSEL])
        aux_pll_ref <= 2'h1;
      else
        aux_pll_ref <= 2'h0;
      locked_d <= locked;
      if (!aclk_reg[`ACS_BIT_AUX_PLL_ENABLE]) begin
        lock_count <= 16'h0000;
        locked     <= 1'b0;
      end else if (lock_count == LOCK_CYCLES[15:0]) begin
        locked <= 1'b1;
      end else begin
        lock_count <= lock_count + 16'h0001;
      end
    end
  end

  acs_aux_divider u_div (
    .clk        (pclk),
    .rst_n      (presetn),
    .src_clk_en (aclk_reg[`ACS_BIT_SRCSEL] ? aux_osc_clk_en :
                 pri_vco_clk_en),
    .div_sel    (aclk_reg[`ACS_DIV_HI:`ACS_DIV_LO]),
    .div_out    (div_clk)
  );

  // events: clock fail, switch done, pll lock gained
  assign evt = {locked & ~locked_d, sw_done, fail_detect};

  // per-bit sticky next value; an event beats a same-cycle clear
  generate
    for (gi = 0; gi < `ACS_IRQ_BITS; gi = gi + 1) begin : g_stat
      assign next_irq_stat[gi] = evt[gi] |
        (irq_stat[gi] & ~(wr_en & hit_irq_clr & pwdata[gi]));
    end
  endgenerate

  // sticky interrupt status and enable, level interrupt
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat    <= 3'h0;
      irq_en      <= 3'h0;
      irq         <= 1'b0;
      aux_clk_out <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      if (wr_en && hit_irq_en)
        irq_en <= pwdata[2:0];
      irq         <= |(irq_stat & irq_en);
      aux_clk_out <= div_clk;
    end
  end

  // read mux; unmapped and unimplemented bits read zero
  // zero fill
  always @* begin
    next_rdata = 32'h00000000;
    if (paddr == `ACS_OFF_OSC)
      next_rdata[15:0] = osc_reg & (`ACS_OSC_WMASK | 16'h0009);
    else if (paddr == `ACS_OFF_ACLK)
      next_rdata[15:0] = aclk_reg | {1'b0, locked, 14'h0000};
    else if (paddr == `ACS_OFF_IRQ_STAT)
      next_rdata[2:0] = irq_stat;
    else if (paddr == `ACS_OFF_IRQ_EN)
      next_rdata[2:0] = irq_en;
    else if (paddr == `ACS_OFF_CUR)
      next_rdata[2:0] = cur_osc;
  end

  // apb answer: no wait state, data latched in setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (rd_en)
        prdata <= next_rdata;
    end
  end

endmodule // acs_clock_ctrl

// >>> design/acs_consts.vh
// register offsets, field positions, reset values and encodings
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
`define ACS_OFF_OSC       12'h000
`define ACS_OFF_ACLK      12'h004
`define ACS_OFF_UNLOCK    12'h008
`define ACS_OFF_IRQ_STAT  12'h00C
`define ACS_OFF_IRQ_EN    12'h010
`define ACS_OFF_IRQ_CLR   12'h014
`define ACS_OFF_CUR       12'h018
`define ACS_UNLOCK_KEY1   16'h0046
`define ACS_UNLOCK_KEY2   16'h0057
`define ACS_ACLK_RESET    16'h2700
`define ACS_OSC_RESET     16'h0000
`define ACS_OSC_WMASK     16'h0700
`define ACS_ACLK_WMASK    16'hA7C0
`define ACS_BIT_AUX_PLL_ENABLE    15
`define ACS_BIT_LOCK      14
`define ACS_BIT_SRCSEL    13
`define ACS_DIV_HI        10
`define ACS_DIV_LO        8
`define ACS_BIT_REFSEL    7
`define ACS_BIT_RCSEL     6
`define ACS_BIT_CF        3
`define ACS_BIT_SWREQ     0
`define ACS_NOSC_HI       10
`define ACS_NOSC_LO       8
`define ACS_OSC_FRC       3'h0
`define ACS_OSC_INTERNAL_RC_WITH_PLL_MODE    3'h1
`define ACS_OSC_PRI       3'h2
`define ACS_OSC_PRIPLL    3'h3
`define ACS_LOCK_CYCLES   16'h0064
`define ACS_SWITCH_CYCLES 8'h10
`define ACS_IRQ_BITS      3
`endif

// >>> verif/acs_clock_ctrl_assertions.sv
// port checker for the aux clock control block
`timescale 1ns/100ps
module acs_clock_ctrl_assertions #(
  parameter LOCK_CYCLES = 100
) (
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // clock control
  input wire        aux_pll_run,
  input wire [1:0]  aux_pll_ref,
  input wire [2:0]  cur_osc
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // completed reads and aux register writes
  wire rd_done = psel && penable && pready && !pwrite;
  wire wr_aclk = psel && penable && pready && pwrite && paddr == 12'h004;
  ready_on_access_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  no_error_a: assert property (!pslverr) else $error("slave error");
  pll_run_a: assert property (
    wr_aclk |=> ##1 aux_pll_run == $past(pwdata[15], 2))
    else $error("pll run not following enable");
  lock_run_a: assert property (
    rd_done && paddr == 12'h004 && prdata[14] |-> aux_pll_run)
    else $error("lock shown while pll stopped");
  ref_code_a: assert property (aux_pll_ref != 2'h3)
    else $error("bad reference code");
  upper_zero_a: assert property (rd_done |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  osc_zero_a: assert property (
    rd_done && paddr == 12'h000 |-> (prdata & 32'h0000F8F6) == 32'h0)
    else $error("osc unused bits set");
  aclk_zero_a: assert property (
    rd_done && paddr == 12'h004 |-> (prdata & 32'h0000183F) == 32'h0)
    else $error("aux unused bits set");
  // a pll mode may only be left for a plain mode
  pll_hop_a: assert property (
    cur_osc[0] |=> cur_osc == $past(cur_osc) || !cur_osc[0])
    else $error("direct pll to pll switch");
endmodule // acs_clock_ctrl_assertions
bind acs_clock_ctrl acs_clock_ctrl_assertions #(
  .LOCK_CYCLES(LOCK_CYCLES)
) acs_chk_i (.*);

// >>> verif/test_aux_clock_and_osc_switch_control.sv
// self-checking bench for the aux clock control block
`timescale 1ns/100ps
module test_aux_clock_and_osc_switch_control;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg         fail_detect = 1'b0;
  reg         aux_en = 1'b1;
  reg         vco_en = 1'b0;
  reg         slow = 1'b0;
  wire [31:0] prdata;
  wire        pready, pslverr, aux_pll_run, aux_clk_out, irq;
  wire [1:0]  aux_pll_ref;
  wire [2:0]  cur_osc;
  integer     err_total = 0;
  integer     total_checks = 0;
  integer     i, p;
  reg  [31:0] q;
  // 250 MHz clock
  always #2 pclk = ~pclk;
  // aux source ticks every cycle, or every other cycle when slow
  always @(posedge pclk) aux_en <= slow ? ~aux_en : 1'b1;
  // short lock count keeps the run brief
  acs_clock_ctrl #(.LOCK_CYCLES(5)) acs_clock_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fail_detect(fail_detect),
    .aux_osc_clk_en(aux_en), .pri_vco_clk_en(vco_en),
    .aux_pll_run(aux_pll_run), .aux_pll_ref(aux_pll_ref),
    .cur_osc(cur_osc), .aux_clk_out(aux_clk_out), .irq(irq));
  task check(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("mismatch %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one apb transfer; idle edge first so no signal is set twice
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // a stuck slave is ended by the watchdog only
      while (pready !== 1'b1)
        @(posedge pclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input string nm, input [11:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      check(nm, q, exp);
    end
  endtask
  task unlock;
    begin
      wr(12'h008, 32'h46);
      wr(12'h008, 32'h57);
    end
  endtask
  // period between second and third output rise, 0 if none
  task period;
    integer c, r;
    reg     l;
    begin
      c = 0;
      r = 0;
      l = aux_clk_out;
      while (r < 3 && c < 1200) begin
        @(posedge pclk);
        c = c + 1;
        if (aux_clk_out && !l) r = r + 1;
        if (aux_clk_out && !l && r == 2) p = c;
        if (aux_clk_out && !l && r == 3) p = c - p;
        l = aux_clk_out;
      end
      if (r < 3) p = 0;
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd("osc", 12'h000, 32'h0);
    rd("aclk", 12'h004, 32'h2700);
    wr(12'h01C, 32'hFFFFFFFF);
    rd("hole", 12'h01C, 32'h0);
    for (i = 0; i < 7; i = i + 1) begin
      wr(12'h004, 32'h2000 | (i << 8));
      period;
      check("ratio", p, (i == 0) ? 256 : (1 << (7 - i)));
    end
    // vco source idle first, then ticking
    wr(12'h004, 32'h0600);
    period;
    check("idle", p, 0);
    vco_en <= 1'b1;
    period;
    check("vco", p, 2);
    // half-rate ticks: divide by 1 passes every tick
    slow <= 1'b1;
    wr(12'h004, 32'h2700);
    period;
    check("bypass", p, 2);
    wr(12'h004, 32'h2600);
    period;
    check("slow", p, 4);
    slow <= 1'b0;
    wr(12'h004, 32'hFFFFFFFF);
    rd("unlock", 12'h004, 32'hA7C0);
    repeat (20) @(posedge pclk);
    rd("lock", 12'h004, 32'hE7C0);
    check("run", {31'h0, aux_pll_run}, 1);
    check("ref", {30'h0, aux_pll_ref}, 2);
    wr(12'h004, 32'h0080);
    repeat (2) @(posedge pclk);
    check("ref", {30'h0, aux_pll_ref}, 1);
    check("run", {31'h0, aux_pll_run}, 0);
    wr(12'h000, 32'h0301);
    rd("guard", 12'h000, 32'h0);
    unlock;
    wr(12'h000, 32'h0301);
    repeat (30) @(posedge pclk);
    rd("switch", 12'h000, 32'h0300);
    check("cur", {29'h0, cur_osc}, 3);
    unlock;
    wr(12'h000, 32'h0101);
    repeat (30) @(posedge pclk);
    check("cur", {29'h0, cur_osc}, 3);
    fail_detect <= 1'b1;
    @(posedge pclk);
    fail_detect <= 1'b0;
    rd("status", 12'h00C, 32'h7);
    apb(1'b0, 12'h000, 32'h0);
    check("fail", q & 32'h8, 32'h8);
    unlock;
    wr(12'h000, 32'h0300);
    apb(1'b0, 12'h000, 32'h0);
    check("fail", q & 32'h8, 32'h0);
    // interrupt raised, masked, cleared
    wr(12'h010, 32'h1);
    repeat (2) @(posedge pclk);
    check("irq", {31'h0, irq}, 1);
    wr(12'h010, 32'h0);
    repeat (2) @(posedge pclk);
    check("irq", {31'h0, irq}, 0);
    wr(12'h010, 32'h7);
    wr(12'h014, 32'h7);
    repeat (2) @(posedge pclk);
    check("irq", {31'h0, irq}, 0);
    rd("status", 12'h00C, 32'h0);
    give_verdict;
  end
  // watchdog against a hang
  initial begin
    #200000;
    err_total = err_total + 1;
    give_verdict;
  end
endmodule // test_aux_clock_and_osc_switch_control
